/* File: hw/etp_defs.vh */
// Constants for the enhanced timer pulse/capture block
`ifndef ETP_DEFS_VH
`define ETP_DEFS_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define ETP_OFF_CTRL1 8'h00
`define ETP_OFF_CTRL2 8'h04
`define ETP_OFF_COMPARE_A_VALUE 8'h08
`define ETP_OFF_COMPARE_B_VALUE 8'h0c
`define ETP_OFF_CNT 8'h10
`define ETP_OFF_FLAG 8'h14
// ----------------------------------------
// Control one fields
// ----------------------------------------
`define ETP_C1_RUN 0
`define ETP_C1_CCLR 1
`define ETP_C1_PER_LO 2
`define ETP_C1_PER_HI 4
`define ETP_C1_ALIGN_LO 5
`define ETP_C1_ALIGN_HI 6
`define ETP_C1_MA_LO 7
`define ETP_C1_MA_HI 8
`define ETP_C1_IOA_LO 9
`define ETP_C1_IOA_HI 10
`define ETP_C1_INITA 11
`define ETP_C1_POLA 12
// ----------------------------------------
// Control two fields
// ----------------------------------------
`define ETP_C2_MB_LO 0
`define ETP_C2_MB_HI 1
`define ETP_C2_IOB_LO 2
`define ETP_C2_IOB_HI 3
`define ETP_C2_INITB 4
`define ETP_C2_POLB 5
`define ETP_C2_BSEL_LO 6
`define ETP_C2_BSEL_HI 7
// ----------------------------------------
// Flag bits and encodings
// ----------------------------------------
`define ETP_FL_A 0
`define ETP_FL_B 1
`define ETP_FL_P 2
`define ETP_MODE_CMP 2'h0
`define ETP_MODE_CAP 2'h1
`define ETP_MODE_PWM 2'h2
`define ETP_MODE_TMR 2'h3
`define ETP_IO_LOW 2'h0
`define ETP_IO_HIGH 2'h1
`define ETP_IO_PWM 2'h2
`define ETP_IO_SPL 2'h3
`define ETP_EDGE_RISE 2'h0
`define ETP_EDGE_FALL 2'h1
`define ETP_EDGE_BOTH 2'h2
`define ETP_ALIGN_CTR 2'h3
`define ETP_CNT_W 10
`define ETP_CNT_ZERO 10'h000
`define ETP_CNT_ONE 10'h001
`define ETP_PER_SHIFT 7
`define ETP_PER_MAX 11'h400
`define ETP_RESP_OK 2'h0
`define ETP_RESP_ERR 2'h2
`endif

/* File: hw/etp_edge_sync.v */
// Two-stage pin synchroniser with edge detect
`timescale 1ns/1ps
module etp_edge_sync (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Pin and results
	input wire pinIn,
	output reg level,
	output wire rise,
	output wire fall
);
	reg meta_r;
	reg sync_r;
	// First stage feeds only the second
	always @(posedge clk) begin
		if (rst) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			level <= 1'b0;
		end else begin
			meta_r <= pinIn;
			sync_r <= meta_r;
			level <= sync_r;
		end
	end
	assign rise = sync_r & ~level;
	assign fall = ~sync_r & level;
endmodule // etp_edge_sync

/* File: hw/etp_timer.v */
// Enhanced timer: centre PWM, single pulse and capture, AXI4-Lite registers
//
// Chosen here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "etp_defs.vh"
module etp_timer (
	// Clock and reset
	input wire clk,
	input wire rst,
	// AXI4-Lite write address and data
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// AXI4-Lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Timer pins
	input wire extTimerClockPin,
	input wire timerPinAIn,
	input wire timerPinBIn,
	output reg timerPinA,
	output reg [2:0] timerPinB
);
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg [12:0] ctrlOne_r;
	reg [7:0] ctrlTwo_r;
	reg [9:0] compare_a_value_r;
	reg [9:0] compare_b_value_r;
	reg [9:0] cnt_r;
	reg [2:0] flag_r;
	reg runPrev_r;
	reg down_r;
	reg outA_r;
	reg outB_r;
	reg awHeld_r;
	reg wHeld_r;
	reg [7:0] awAddr_r;
	reg [31:0] wData_r;
	reg [3:0] wStrb_r;
	wire ckLvl, ckRise, ckFall, aLvl, aRise, aFall, bLvl, bRise, bFall;
	etp_edge_sync uSyncCk (.clk(clk), .rst(rst), .pinIn(extTimerClockPin),
		.level(ckLvl), .rise(ckRise), .fall(ckFall));
	etp_edge_sync uSyncA (.clk(clk), .rst(rst), .pinIn(timerPinAIn),
		.level(aLvl), .rise(aRise), .fall(aFall));
	etp_edge_sync uSyncB (.clk(clk), .rst(rst), .pinIn(timerPinBIn),
		.level(bLvl), .rise(bRise), .fall(bFall));
	// ----------------------------------------
	// Field decode
	// ----------------------------------------
	wire run = ctrlOne_r[`ETP_C1_RUN];
	wire cclr = ctrlOne_r[`ETP_C1_CCLR];
	wire [2:0] perField = ctrlOne_r[`ETP_C1_PER_HI:`ETP_C1_PER_LO];
	wire [1:0] alignSel = ctrlOne_r[`ETP_C1_ALIGN_HI:`ETP_C1_ALIGN_LO];
	wire [1:0] modeA = ctrlOne_r[`ETP_C1_MA_HI:`ETP_C1_MA_LO];
	wire [1:0] ioA = ctrlOne_r[`ETP_C1_IOA_HI:`ETP_C1_IOA_LO];
	wire [1:0] modeB = ctrlTwo_r[`ETP_C2_MB_HI:`ETP_C2_MB_LO];
	wire [1:0] ioB = ctrlTwo_r[`ETP_C2_IOB_HI:`ETP_C2_IOB_LO];
	wire [1:0] bSel = ctrlTwo_r[`ETP_C2_BSEL_HI:`ETP_C2_BSEL_LO];
	wire runRise = run & ~runPrev_r;
	wire capMode = (modeA == `ETP_MODE_CAP) && (modeB == `ETP_MODE_CAP);
	wire pwmMode = (modeA == `ETP_MODE_PWM) && (ioA != `ETP_IO_SPL);
	wire splMode = (modeA == `ETP_MODE_PWM) && (ioA == `ETP_IO_SPL) && (ioB == `ETP_IO_SPL);
	wire centre = pwmMode && (alignSel == `ETP_ALIGN_CTR);
	// Period field 000 means the full 1024 count
	wire [10:0] perSpan = (perField == 3'h0) ? `ETP_PER_MAX : ({8'h00, perField} << `ETP_PER_SHIFT);
	wire [9:0] perTop = perSpan[9:0] - `ETP_CNT_ONE;
	// Centre mode turns at the span itself, so 000 saturates at the top count
	wire [9:0] centreTop = (perField == 3'h0) ? perTop : perSpan[9:0];
	wire [9:0] topVal = (cclr && !capMode) ? compare_a_value_r : (centre ? centreTop : perTop);
	wire matchA = run && (cnt_r == compare_a_value_r);
	wire matchB = run && (cnt_r == compare_b_value_r);
	wire matchP = run && (cnt_r == topVal);
	// Capture edge decision per pin
	function capHit;
		input [1:0] sel;
		input r;
		input f;
		begin
			case (sel)
				`ETP_EDGE_RISE: capHit = r;
				`ETP_EDGE_FALL: capHit = f;
				`ETP_EDGE_BOTH: capHit = r | f;
				default: capHit = 1'b0;
			endcase
		end
	endfunction
	// Shared pins count only in capture mode, where their outputs are held low
	wire capA = capMode && run && capHit(ioA, aRise, aFall);
	wire capB = capMode && run && capHit(ioB, bRise, bFall);
	// Forced or waveform pin level
	function pinLvl;
		input [1:0] io;
		input wave;
		input pol;
		begin
			case (io)
				`ETP_IO_LOW: pinLvl = 1'b0;
				`ETP_IO_HIGH: pinLvl = 1'b1;
				default: pinLvl = wave ^ pol;
			endcase
		end
	endfunction
	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------
	// Ready pulses once per beat; a held beat waits here until the previous response is taken
	wire wrGo = awHeld_r && wHeld_r && !s_axi_bvalid;
	wire wrCtrl1 = wrGo && (awAddr_r == `ETP_OFF_CTRL1);
	wire wrFlag = wrGo && (awAddr_r == `ETP_OFF_FLAG);
	wire wrKnown = (awAddr_r == `ETP_OFF_CTRL1) || (awAddr_r == `ETP_OFF_CTRL2) ||
		(awAddr_r == `ETP_OFF_COMPARE_A_VALUE) || (awAddr_r == `ETP_OFF_COMPARE_B_VALUE) || (awAddr_r == `ETP_OFF_FLAG);
	always @(posedge clk) begin
		if (rst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `ETP_RESP_OK;
			awHeld_r <= 1'b0;
			wHeld_r <= 1'b0;
			awAddr_r <= 8'h00;
			wData_r <= 32'h0000_0000;
			wStrb_r <= 4'h0;
		end else begin
			s_axi_awready <= !awHeld_r && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !wHeld_r && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld_r <= 1'b1;
				awAddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld_r <= 1'b1;
				wData_r <= s_axi_wdata;
				wStrb_r <= s_axi_wstrb;
			end
			if (wrGo) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wrKnown ? `ETP_RESP_OK : `ETP_RESP_ERR;
				awHeld_r <= 1'b0;
				wHeld_r <= 1'b0;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	always @(posedge clk) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `ETP_RESP_OK;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `ETP_RESP_OK;
				case (s_axi_araddr)
					`ETP_OFF_CTRL1: s_axi_rdata <= {19'h0, ctrlOne_r};
					`ETP_OFF_CTRL2: s_axi_rdata <= {24'h0, ctrlTwo_r};
					`ETP_OFF_COMPARE_A_VALUE: s_axi_rdata <= {22'h0, compare_a_value_r};
					`ETP_OFF_COMPARE_B_VALUE: s_axi_rdata <= {22'h0, compare_b_value_r};
					`ETP_OFF_CNT: s_axi_rdata <= {22'h0, cnt_r};
					`ETP_OFF_FLAG: s_axi_rdata <= {29'h0, flag_r};
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= `ETP_RESP_ERR;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
	// ----------------------------------------
	// Control and compare registers
	// ----------------------------------------
	// Hardware run changes beat a software write in the same cycle
	always @(posedge clk) begin
		if (rst) begin
			ctrlOne_r <= 13'h0000;
			ctrlTwo_r <= 8'h00;
			compare_a_value_r <= `ETP_CNT_ZERO;
			compare_b_value_r <= `ETP_CNT_ZERO;
		end else begin
			if (wrCtrl1 && wStrb_r[0])
				ctrlOne_r[7:0] <= wData_r[7:0];
			if (wrCtrl1 && wStrb_r[1])
				ctrlOne_r[12:8] <= wData_r[12:8];
			if (wrGo && (awAddr_r == `ETP_OFF_CTRL2) && wStrb_r[0])
				ctrlTwo_r <= wData_r[7:0];
			if (wrGo && (awAddr_r == `ETP_OFF_COMPARE_A_VALUE) && wStrb_r[0])
				compare_a_value_r[7:0] <= wData_r[7:0];
			if (wrGo && (awAddr_r == `ETP_OFF_COMPARE_A_VALUE) && wStrb_r[1])
				compare_a_value_r[9:8] <= wData_r[9:8];
			if (wrGo && (awAddr_r == `ETP_OFF_COMPARE_B_VALUE) && wStrb_r[0])
				compare_b_value_r[7:0] <= wData_r[7:0];
			if (wrGo && (awAddr_r == `ETP_OFF_COMPARE_B_VALUE) && wStrb_r[1])
				compare_b_value_r[9:8] <= wData_r[9:8];
			if (splMode && !run && ckRise)
				ctrlOne_r[`ETP_C1_RUN] <= 1'b1;
			// A stale count left from the last pulse must not end the new one
			if (splMode && matchA && !runRise)
				ctrlOne_r[`ETP_C1_RUN] <= 1'b0;
			if (capA)
				compare_a_value_r <= cnt_r;
			if (capB)
				compare_b_value_r <= cnt_r;
		end
	end
	// ----------------------------------------
	// Counter
	// ----------------------------------------
	always @(posedge clk) begin
		if (rst) begin
			cnt_r <= `ETP_CNT_ZERO;
			down_r <= 1'b0;
			runPrev_r <= 1'b0;
		end else begin
			runPrev_r <= run;
			if (runRise) begin
				cnt_r <= `ETP_CNT_ZERO;
				down_r <= 1'b0;
			end else if (!run) begin
				down_r <= 1'b0;
			end else if (splMode) begin
				cnt_r <= cnt_r + `ETP_CNT_ONE;
			end else if (centre) begin
				// Up to the top, then back down to zero
				if (!down_r && cnt_r >= topVal) begin
					down_r <= 1'b1;
					cnt_r <= cnt_r - `ETP_CNT_ONE;
				end else if (down_r && cnt_r == `ETP_CNT_ZERO) begin
					down_r <= 1'b0;
					cnt_r <= `ETP_CNT_ONE;
				end else if (down_r) begin
					cnt_r <= cnt_r - `ETP_CNT_ONE;
				end else begin
					cnt_r <= cnt_r + `ETP_CNT_ONE;
				end
			end else if (matchP) begin
				cnt_r <= `ETP_CNT_ZERO;
			end else begin
				cnt_r <= cnt_r + `ETP_CNT_ONE;
			end
		end
	end
	// ----------------------------------------
	// Flags, set wins over software clear
	// ----------------------------------------
	wire setA = (!capMode && matchA) || capA;
	wire setB = (!capMode && matchB) || capB;
	// Centre mode flags the period at the bottom of the down slope
	wire setP = centre ? (run && down_r && cnt_r == `ETP_CNT_ZERO) :
		(matchP && !splMode && (capMode || !cclr));
	always @(posedge clk) begin
		if (rst) begin
			flag_r <= 3'h0;
		end else begin
			// Write one to clear
			flag_r <= (flag_r & ~((wrFlag && wStrb_r[0]) ? wData_r[2:0] : 3'h0)) | {setP, setB, setA};
		end
	end
	// ----------------------------------------
	// Output waveforms
	// ----------------------------------------
	always @(posedge clk) begin
		if (rst) begin
			outA_r <= 1'b0;
			outB_r <= 1'b0;
		end else if (runRise) begin
			outA_r <= splMode ? 1'b0 : ctrlOne_r[`ETP_C1_INITA];
			outB_r <= splMode ? 1'b0 : ctrlTwo_r[`ETP_C2_INITB];
		end else if (splMode) begin
			if (!run || matchA) begin
				outA_r <= 1'b0;
				outB_r <= 1'b0;
			end else begin
				// Leading edge one cycle after the restart keeps the width equal to compare A
				if (cnt_r == `ETP_CNT_ZERO)
					outA_r <= 1'b1;
				if (matchB)
					outB_r <= 1'b1;
			end
		end else if (pwmMode && run) begin
			// Waveform runs regardless of pin forcing
			outA_r <= cnt_r < compare_a_value_r;
			outB_r <= cnt_r < compare_b_value_r;
		end else if (!run) begin
			outA_r <= ctrlOne_r[`ETP_C1_INITA];
			outB_r <= ctrlTwo_r[`ETP_C2_INITB];
		end
	end
	wire pinAVal = capMode ? 1'b0 : pinLvl(ioA, outA_r ^ ~ctrlOne_r[`ETP_C1_INITA], ctrlOne_r[`ETP_C1_POLA]);
	wire pinBVal = capMode ? 1'b0 : pinLvl(ioB, outB_r ^ ~ctrlTwo_r[`ETP_C2_INITB], ctrlTwo_r[`ETP_C2_POLB]);
	always @(posedge clk) begin
		if (rst) begin
			timerPinA <= 1'b0;
			timerPinB <= 3'h0;
		end else begin
			timerPinA <= (pwmMode && cclr) ? 1'b0 : (splMode ? outA_r : pinAVal);
			timerPinB <= {bSel == 2'h2, bSel == 2'h1, bSel == 2'h0} & {3{splMode ? outB_r : pinBVal}};
		end
	end
	wire unusedPins = ckLvl & ckFall & aLvl & bLvl;
endmodule // etp_timer

/* File: tb/etp_pin_model.sv */
// Far-side pin driver with a settable answer delay
`timescale 1ns/1ps
module etp_pin_model (
	// Clock
	input wire clk,
	// Requested levels {ext, b, a} and delay in cycles
	input wire [2:0] want,
	input wire [3:0] lag,
	// Pins into the timer
	output wire extPin,
	output wire pinB,
	output wire pinA
);
	logic [2:0] hist [0:15];
	integer k;
	initial begin
		for (k = 0; k < 16; k++) hist[k] = 3'h0;
	end
	// A slow source is modelled by a delay line, not by glitches
	always @(posedge clk) begin
		hist[0] <= want;
		for (k = 1; k < 16; k++) hist[k] <= hist[k-1];
	end
	assign {extPin, pinB, pinA} = hist[lag];
endmodule // etp_pin_model

/* File: tb/etp_timer_checker.sv */
// Bus handshake and output checker for the timer
`timescale 1ns/1ps
module etp_timer_checker (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Bus
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0] s_axi_rresp,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	// Pins
	input wire timerPinA,
	input wire [2:0] timerPinB
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_bad_ar;
		s_axi_arvalid && s_axi_arready && (s_axi_araddr > 8'h14 || s_axi_araddr[1:0] != 2'h0);
	endsequence
	sequence s_err_r;
		s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
	endsequence
	sequence s_bad_aw;
		s_axi_awvalid && s_axi_awready && (s_axi_awaddr > 8'h14 || s_axi_awaddr[1:0] != 2'h0
			|| s_axi_awaddr == 8'h10);
	endsequence
	a_rd_unmapped: assert property (s_bad_ar |=> s_err_r) else $error("unmapped read not refused");
	a_wr_unmapped: assert property (s_bad_aw |-> ##[1:4] (s_axi_bvalid && s_axi_bresp == 2'h2))
		else $error("unmapped write not refused");
	a_rd_ok: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr <= 8'h14 && s_axi_araddr[1:0] == 2'h0
		|=> s_axi_rvalid && s_axi_rresp == 2'h0) else $error("mapped read answer wrong");
	a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready) else $error("awready held");
	a_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready) else $error("arready held");
	a_b_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid held");
	a_r_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid held");
	// Reset leaves bvalid, rvalid and both timer pin outputs idle
	a_reset_idle: assert property ($fell(rst) |-> !s_axi_bvalid && !s_axi_rvalid && !timerPinA
		&& timerPinB == 3'h0) else $error("outputs busy after reset");
	a_pin_b_one: assert property ($onehot0(timerPinB)) else $error("B wave on two pins");
endmodule // etp_timer_checker

/* File: tb/etp_timer_tb.sv */
// Self-checking bench for the timer block
`timescale 1ns/1ps
module etp_timer_tb;
	logic clk, rst, awv, wv, bre, arv, rre, clrHi;
	logic [7:0] awa, ara;
	logic [31:0] wd, rdD;
	logic [1:0] rr, rb;
	int model[$];
	logic [2:0] want;
	logic [3:0] lag;
	wire awr, wrdy, bv, arr, rv, ext, pa, pb, tA;
	wire [1:0] br, rresp;
	wire [31:0] rdata;
	wire [2:0] tB;
	integer bad_count, n_tests, cyc, hiA, hiB, i, a, b, t0, tp, c1;
	etp_timer dut_u (.clk(clk), .rst(rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(br),
		.s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rre),
		.extTimerClockPin(ext), .timerPinAIn(pa), .timerPinBIn(pb), .timerPinA(tA), .timerPinB(tB));
	etp_pin_model pm_u (.clk(clk), .want(want), .lag(lag), .extPin(ext), .pinB(pb), .pinA(pa));
	initial begin
		clk = 0;
		forever #25 clk = ~clk;
	end
	// Pin high-time counters measure the pulse widths on tA and tB[0]
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (clrHi) begin
			hiA <= 0;
			hiB <= 0;
		end else begin
			hiA <= hiA + tA;
			hiB <= hiB + tB[0];
		end
	end
	function logic near(input integer s, input integer e, input integer tol);
		near = (s - e <= tol) && (e - s <= tol);
	endfunction
	task chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			bad_count++;
			$display("ERROR %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task print_verdict;
		if (bad_count == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task hang;
		bad_count++;
		$display("ERROR %0t bus wait timed out", $time);
		print_verdict;
	endtask
	task wr(input [7:0] ad, input [31:0] d);
		@(posedge clk);
		if (ad == 8'h08 || ad == 8'h0c) model.push_back(d & 32'h3ff);
		awa <= ad;
		wd <= d;
		awv <= 1;
		wv <= 1;
		bre <= 1;
		for (i = 0; i < 60; i++) begin
			@(posedge clk);
			if (awr) awv <= 0;
			if (wrdy) wv <= 0;
			if (bv) begin
				rb = br;
				break;
			end
		end
		bre <= 0;
		if (i == 60) hang;
	endtask
	task rd(input [7:0] ad);
		@(posedge clk);
		ara <= ad;
		arv <= 1;
		rre <= 1;
		for (i = 0; i < 60; i++) begin
			@(posedge clk);
			if (arr) arv <= 0;
			if (rv) begin
				rdD = rdata;
				rr = rresp;
				break;
			end
		end
		rre <= 0;
		if (i == 60) hang;
	endtask
	initial begin
		{rst, clrHi} = 2'h3;
		{awv, wv, bre, arv, rre} = 5'h0;
		{awa, ara, wd, want, lag} = 0;
		{cyc, bad_count, n_tests, hiA, hiB} = 0;
		void'($urandom(19180));
		repeat (20) @(posedge clk);
		rst <= 0;
		rd(8'h00);
		chk(rdD, 0);
		rd(8'h18);
		chk({rdD[29:0], rr}, 2);
		wr(8'h18, 1);
		chk(rb, 2);
		// Single pulse with random widths
		a = 16 + $urandom % 32;
		b = 2 + $urandom % 8;
		wr(8'h08, a);
		chk(rb, 0);
		wr(8'h0c, b);
		rd(8'h08);
		chk(rdD, model.pop_front());
		rd(8'h0c);
		chk(rdD, model.pop_front());
		wr(8'h04, 32'h0e);
		wr(8'h00, 32'h700);
		clrHi <= 0;
		wr(8'h00, 32'h701);
		repeat (120) @(posedge clk);
		chk(hiA, a);
		chk(hiB, a - b);
		rd(8'h00);
		chk(rdD[0], 0);
		rd(8'h14);
		chk(rdD[1:0], 3);
		// External clock pin restarts the pulse, slow source
		wr(8'h14, 7);
		clrHi <= 1;
		lag <= 4'h5;
		@(posedge clk);
		clrHi <= 0;
		want <= 3'h4;
		repeat (120) @(posedge clk);
		want <= 3'h0;
		chk(hiA, a);
		// Capture, with unused bits set to show they are ignored
		lag <= 4'h0;
		wr(8'h14, 7);
		wr(8'h04, 32'h05);
		wr(8'h00, 32'h1886);
		wr(8'h00, 32'h1887);
		t0 = cyc;
		repeat (20) @(posedge clk);
		want <= 3'h1;
		tp = cyc;
		repeat (10) @(posedge clk);
		rd(8'h08);
		chk(near(rdD, tp - t0 + 5, 4), 1);
		want <= 3'h3;
		repeat (5) @(posedge clk);
		want <= 3'h1;
		tp = cyc;
		repeat (10) @(posedge clk);
		rd(8'h0c);
		chk(near(rdD, tp - t0 + 5, 4), 1);
		rd(8'h14);
		chk(rdD[1:0], 3);
		// Both select bits high: no capture, counter keeps going
		wr(8'h14, 7);
		wr(8'h00, 32'h1e87);
		want <= 3'h0;
		repeat (5) @(posedge clk);
		want <= 3'h1;
		repeat (10) @(posedge clk);
		rd(8'h14);
		chk(rdD[0], 0);
		rd(8'h10);
		c1 = rdD;
		rd(8'h10);
		chk(rdD !== c1, 1);
		repeat (140) @(posedge clk);
		rd(8'h14);
		chk(rdD[2], 1);
		rd(8'h10);
		chk(rdD < 128, 1);
		// Centre PWM with the pins forced low
		wr(8'h04, 32'h02);
		wr(8'h00, 32'h164);
		wr(8'h14, 7);
		clrHi <= 1;
		wr(8'h00, 32'h165);
		clrHi <= 0;
		repeat (200) @(posedge clk);
		rd(8'h14);
		chk(rdD[2], 0);
		repeat (100) @(posedge clk);
		rd(8'h14);
		chk(rdD[2], 1);
		chk(hiA, 0);
		chk(hiB, 0);
		// Compare A takes over the centre period
		wr(8'h08, 20);
		rd(8'h08);
		chk(rdD, model.pop_front());
		wr(8'h00, 32'h167);
		repeat (300) @(posedge clk);
		rd(8'h10);
		chk(rdD <= 20, 1);
		// B output forced high, routed to the second pin
		wr(8'h04, 32'h46);
		repeat (3) @(posedge clk);
		chk(tB, 3'h2);
		print_verdict;
	end
endmodule // etp_timer_tb
bind etp_timer etp_timer_checker chk_u (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timerPinA, .timerPinB);
